// file: shared/cwgss_pkg.sv
/*
 * cwgss_pkg: register map, field positions, reset values and carrier types
 * for the shutdown and source-select slice of a complementary waveform generator.
 * assumes: 32-bit avalon-mm word addressing on byte offsets, one clock domain.
 */
package cwgss_pkg;
   // register byte offsets
   localparam logic [3:0] OFF_LEVEL_SRC   = 4'h0;   // shutdown levels and source select
   localparam logic [3:0] OFF_STATUS_CTRL = 4'h4;   // event flag and restart control
   localparam logic [3:0] OFF_OUT_CTRL    = 4'h8;   // polarity, output enables, dead band
   localparam logic [3:0] OFF_IRQ_STATUS  = 4'hC;   // sticky event bits, write one clears
   localparam logic [3:0] OFF_IRQ_MASK    = 4'h0;   // placed in a second window, see below
   localparam logic [4:0] OFF_IRQ_MASK_W  = 5'h10;  // interrupt mask word
   // level/source register fields
   localparam int POS_LVL_B = 6;   // shutdown level of output b
   localparam int POS_LVL_A = 4;   // shutdown level of output a
   localparam int POS_SRC   = 0;   // input source select
   // status/control fields
   localparam int POS_EVT     = 7; // shutdown event flag
   localparam int POS_ARS     = 6; // auto restart enable
   localparam int POS_SDSRC   = 0; // four shutdown source enables, bits 3:0
   // output control fields
   localparam int POS_POL_A   = 0;
   localparam int POS_POL_B   = 1;
   localparam int POS_OE_A    = 2;
   localparam int POS_OE_B    = 3;
   localparam int POS_DB      = 8; // dead band count, bits 13:8
   // shutdown level codes
   localparam logic [1:0] LVL_INACTIVE = 2'h0;
   localparam logic [1:0] LVL_TRISTATE = 2'h1;
   localparam logic [1:0] LVL_LOW      = 2'h2;
   localparam logic [1:0] LVL_HIGH     = 2'h3;
   // reset values
   localparam logic [7:0]  RST_LEVEL_SRC   = 8'h00;
   localparam logic [7:0]  RST_STATUS_CTRL = 8'h00;
   localparam logic [13:0] RST_OUT_CTRL    = 14'h0000;
   localparam logic [1:0]  RST_IRQ         = 2'h0;
   // write masks
   localparam logic [7:0] MASK_LEVEL_SRC = 8'hF7;   // bit 3 not implemented
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   // source inputs carried together, indexed by select code
   typedef struct packed {
      logic logic_cell1_output;        // code 7
      logic oscillator1_output;        // code 6
      logic pulse_gen4_output;         // code 5
      logic pulse_gen3_output;         // code 4
      logic pulse_gen2_output;         // code 3
      logic pulse_gen1_output;         // code 2
      logic comparator2_async_output;  // code 1
      logic comparator1_async_output;  // code 0
   } cwgss_src_t;
   // one two-way pin: output, enable (low = driving)
   typedef struct packed {
      logic o;
      logic oe_n;
   } cwgss_pin_t;
endpackage

// file: verilog/cwgss_top.sv
/*
 * cwgss_top: shutdown override, source select, restart and register slave
 * of a complementary waveform generator, with a simple dead-band core.
 * assumes: avalon-mm master with waitrequest on clk, inputs synchronous to clk,
 * shutdown sources active high.
 */
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module cwgss_top
   import cwgss_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic [4:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   input  wire cwgss_pkg::cwgss_src_t  sources,
   input  wire logic [3:0]             shutdown_inputs,
   output logic                        output_a,
   output logic                        output_a_oe_n,
   output logic                        output_b,
   output logic                        output_b_oe_n,
   output logic                        irq
);
   import cwgss_pkg::*;

   logic        rst_meta;          // reset release stage one
   logic        rst_n;             // synchronised reset
   logic [7:0]  level_src;         // shutdown levels and source select
   logic        shutdown_event_flag;
   logic        auto_restart_enable;
   logic [3:0]  sd_enable;         // shutdown source enables
   logic [13:0] out_ctrl;          // polarity, enables, dead band
   logic [1:0]  irq_status;        // 0: shutdown entered, 1: restart
   logic [1:0]  irq_mask;
   logic        src_prev;          // previous selected source
   logic        hold;              // overrides held after flag clears
   logic [5:0]  db_cnt;            // dead-band counter
   logic        wave_a;            // core waveform a, before polarity
   logic        wave_b;            // core waveform b, before polarity
   logic        src_sel;
   logic        sd_active;
   logic        src_rise;
   logic        override;
   logic        wr_hit;
   logic        rd_go;

   // byte-lane merge of write data into a narrow register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      merge = old;
      if (be[0]) merge[7:0] = wd[7:0];
      if (be[1]) merge[15:8] = wd[15:8];
   endfunction

   // source picked by the three-bit code
   assign src_sel   = sources[level_src[POS_SRC +: 3]];
   assign sd_active = |(shutdown_inputs & sd_enable);
   assign src_rise  = src_sel & ~src_prev;
   assign override  = shutdown_event_flag | hold;
   assign wr_hit    = avs_write & ~avs_waitrequest;
   assign rd_go     = avs_read & avs_waitrequest;

   // reset release through two flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // one wait cycle per access, then answer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read | avs_write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // read data, captured in the wait cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= UNMAPPED_DATA;
      end else if (rd_go) begin
         if (avs_address[4:0] == {1'b0, OFF_LEVEL_SRC}) begin
            avs_readdata <= {24'h00_0000, level_src & MASK_LEVEL_SRC};
         end else if (avs_address[4:0] == {1'b0, OFF_STATUS_CTRL}) begin
            avs_readdata <= {24'h00_0000, shutdown_event_flag,
                             auto_restart_enable, 2'h0, sd_enable};
         end else if (avs_address[4:0] == {1'b0, OFF_OUT_CTRL}) begin
            avs_readdata <= {18'h0_0000, out_ctrl};
         end else if (avs_address[4:0] == {1'b0, OFF_IRQ_STATUS}) begin
            avs_readdata <= {30'h0000_0000, irq_status};
         end else if (avs_address[4:0] == OFF_IRQ_MASK_W) begin
            avs_readdata <= {30'h0000_0000, irq_mask};
         end else begin
            avs_readdata <= UNMAPPED_DATA;                                 // unmapped
         end
      end
   end

   // plain configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_src           <= RST_LEVEL_SRC;
         auto_restart_enable <= RST_STATUS_CTRL[POS_ARS];
         sd_enable           <= RST_STATUS_CTRL[3:0];
         out_ctrl            <= RST_OUT_CTRL;
         irq_mask            <= RST_IRQ;
      end else if (wr_hit) begin
         if (avs_address == {1'b0, OFF_LEVEL_SRC} && avs_byteenable[0]) begin
            level_src <= avs_writedata[7:0] & MASK_LEVEL_SRC;
         end else if (avs_address == {1'b0, OFF_STATUS_CTRL} && avs_byteenable[0]) begin
            auto_restart_enable <= avs_writedata[POS_ARS];
            sd_enable           <= avs_writedata[POS_SDSRC +: 4];
         end else if (avs_address == {1'b0, OFF_OUT_CTRL}) begin
            out_ctrl <= 14'(merge({2'b00, out_ctrl}, avs_writedata, avs_byteenable));
         end else if (avs_address == OFF_IRQ_MASK_W && avs_byteenable[0]) begin
            irq_mask <= avs_writedata[1:0];
         end
      end
   end

   // event flag: set by any enabled source, set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shutdown_event_flag <= RST_STATUS_CTRL[POS_EVT];
      end else if (sd_active) begin
         shutdown_event_flag <= 1'b1;
      end else if (auto_restart_enable) begin
         shutdown_event_flag <= 1'b0;
      end else if (wr_hit && avs_address == {1'b0, OFF_STATUS_CTRL} &&
                   avs_byteenable[0] && !avs_writedata[POS_EVT]) begin
         shutdown_event_flag <= 1'b0;
      end
   end

   // hold overrides from flag clear to next source rise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold     <= 1'b0;
         src_prev <= 1'b0;
      end else begin
         src_prev <= src_sel;
         if (shutdown_event_flag) begin
            hold <= 1'b1;
         end else if (src_rise) begin
            hold <= 1'b0;
         end
      end
   end

   // dead-band core: a follows rise after delay, b follows fall after delay
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         db_cnt <= 6'h00;
         wave_a <= 1'b0;
         wave_b <= 1'b0;
      end else if (src_sel != src_prev) begin
         db_cnt <= out_ctrl[POS_DB +: 6];
         wave_a <= 1'b0;
         wave_b <= 1'b0;
      end else if (db_cnt != 6'h00) begin
         db_cnt <= db_cnt - 6'h01;
      end else begin
         wave_a <= src_sel;
         wave_b <= ~src_sel;
      end
   end

   // pin a: override or polarity-applied waveform
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         output_a      <= 1'b0;
         output_a_oe_n <= 1'b1;
      end else if (override) begin
         output_a_oe_n <= (level_src[POS_LVL_A +: 2] == LVL_TRISTATE);
         if (level_src[POS_LVL_A +: 2] == LVL_HIGH) begin
            output_a <= 1'b1;
         end else if (level_src[POS_LVL_A +: 2] == LVL_LOW) begin
            output_a <= 1'b0;
         end else begin
            output_a <= out_ctrl[POS_POL_A];
         end
      end else begin
         output_a_oe_n <= ~out_ctrl[POS_OE_A];
         output_a      <= out_ctrl[POS_POL_A] ^ wave_a;
      end
   end

   // pin b: override or polarity-applied waveform
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         output_b      <= 1'b0;
         output_b_oe_n <= 1'b1;
      end else if (override) begin
         output_b_oe_n <= (level_src[POS_LVL_B +: 2] == LVL_TRISTATE);
         if (level_src[POS_LVL_B +: 2] == LVL_HIGH) begin
            output_b <= 1'b1;
         end else if (level_src[POS_LVL_B +: 2] == LVL_LOW) begin
            output_b <= 1'b0;
         end else begin
            output_b <= out_ctrl[POS_POL_B];
         end
      end else begin
         output_b_oe_n <= ~out_ctrl[POS_OE_B];
         output_b      <= out_ctrl[POS_POL_B] ^ wave_b;
      end
   end

   // sticky interrupt bits, write one clears, set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= RST_IRQ;
         irq        <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == 0) ? (sd_active & ~shutdown_event_flag)
                         : (~shutdown_event_flag & hold & src_rise)) begin
               irq_status[i] <= 1'b1;
            end else if (wr_hit && avs_address == {1'b0, OFF_IRQ_STATUS} &&
                         avs_byteenable[0] && avs_writedata[i]) begin
               irq_status[i] <= 1'b0;
            end
         end
         irq <= |(irq_status & irq_mask);
      end
   end
endmodule

// file: verification/cwgss_properties.sv
/* checker: bus handshake and shutdown pin overrides at the top ports.
   assumes: bound onto cwgss_top, one clock, byteenable full on writes. */
`timescale 1ns/1ns
module cwgss_properties
   import cwgss_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [3:0]  shutdown_inputs,
   input wire logic        output_a,
   input wire logic        output_a_oe_n,
   input wire logic        output_b,
   input wire logic        output_b_oe_n
);
   logic [7:0] lvl;   // shadow of level/source register
   logic [3:0] en;    // shadow of shutdown source enables
   wire        sd  = |(shutdown_inputs & en);   // enabled source high
   wire        req = avs_read | avs_write;      // any request
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // follow register writes at the edge they take effect
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lvl <= 8'h00;
         en  <= 4'h0;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
         if (avs_address == 5'h00) lvl <= avs_writedata[7:0];
         if (avs_address == 5'h04) en <= avs_writedata[3:0];
      end
   end
   AST_ANSWER: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   AST_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   AST_NO_SPUR: assert property (!req && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without request");
   AST_B_HIGH: assert property (sd && $past(sd) && lvl[7:6] == 2'h3 |=> output_b && !output_b_oe_n)
      else $error("output b not forced high");
   AST_B_LOW: assert property (sd && $past(sd) && lvl[7:6] == 2'h2 |=> !output_b && !output_b_oe_n)
      else $error("output b not forced low");
   AST_A_FORCE: assert property (sd && $past(sd) && lvl[5] |=> output_a == $past(lvl[4]) && !output_a_oe_n)
      else $error("output a not forced to level");
   AST_TRI_A: assert property (sd && $past(sd) && lvl[5:4] == 2'h1 |=> output_a_oe_n)
      else $error("output a not released");
   AST_TRI_B: assert property (sd && $past(sd) && lvl[7:6] == 2'h1 |=> output_b_oe_n)
      else $error("output b not released");
   AST_RSV: assert property (avs_read && !avs_waitrequest && avs_address == 5'h00 |-> !avs_readdata[3])
      else $error("unimplemented bit reads one");
endmodule
bind cwgss_top cwgss_properties u_chk (.*);

// file: verification/cwgss_pins.sv
/* far side: switch drivers on the two output pins.
   assumes: pins pulled up when the block releases them. */
`timescale 1ns/1ns
module cwgss_pins (
   input wire logic output_a,
   input wire logic output_a_oe_n,
   input wire logic output_b,
   input wire logic output_b_oe_n,
   output logic     pin_a,
   output logic     pin_b
);
   // released pin floats to the pull-up level
   assign pin_a = output_a_oe_n ? 1'b1 : output_a;
   assign pin_b = output_b_oe_n ? 1'b1 : output_b;
endmodule

// file: verification/cwgss_top_tb_top.sv
/* testbench: registers, source select, shutdown levels, restart modes.
   assumes: cwgss_top with bound checker, pin model with pull-ups. */
`timescale 1ns/1ns
module cwgss_top_tb_top;
   import cwgss_pkg::*;
   logic        clk, reset_n, avs_read, avs_write, avs_waitrequest, irq;
   logic        output_a, output_a_oe_n, output_b, output_b_oe_n, pin_a, pin_b;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable, shutdown_inputs, ex;
   cwgss_src_t  sources;
   int          failures, check_count;
   logic [31:0] expq[$];   // expected read data, oldest first
   cwgss_top dut (.*);
   cwgss_pins u_pins (.*);
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // one avalon access, held until waitrequest seen low
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task rd(input logic [4:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task cmp_rd(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t read %h expected %h", $time, g, e);
      end
   endtask
   // pins {a_oe_n, a, b_oe_n, b} after settling, masked
   task cmp_pin(input logic [3:0] m, input logic [3:0] e);
      repeat (4) @(posedge clk);
      @(negedge clk);
      check_count++;
      if ((({output_a_oe_n, pin_a, output_b_oe_n, pin_b} ^ e) & m) !== 4'h0) begin
         failures++;
         $display("[FAIL] %0t pins differ from %b", $time, e);
      end
      @(posedge clk);
   endtask
   // read results compared as they appear
   always @(posedge clk)
      if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0)
         cmp_rd(avs_readdata, expq.pop_front());
   task report_and_stop;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      report_and_stop;
   end
   initial begin
      {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {shutdown_inputs, sources, failures, check_count} = '0;
      avs_byteenable = 4'hF;
      void'($urandom(32'hc1af));
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(5'h00, 32'h0000_0000);
      rd(5'h04, 32'h0000_0000);
      bus(1'b1, 5'h00, 32'h0000_00FF);
      rd(5'h00, 32'h0000_00F7);
      rd(5'h14, 32'h0000_0000);
      $display("registers done");
      bus(1'b1, 5'h08, 32'h0000_000C);
      for (int c = 0; c < 8; c++)
         for (int v = 0; v < 2; v++) begin
            bus(1'b1, 5'h00, c);
            sources <= (8'($urandom) & ~(8'h01 << c)) | (8'(v) << c);
            cmp_pin(4'hF, {1'b0, v[0], 1'b0, !v[0]});
         end
      $display("source select done");
      sources <= 8'h00;
      bus(1'b1, 5'h10, 32'h0000_0003);
      bus(1'b1, 5'h04, 32'h0000_0001);
      for (int c = 0; c < 4; c++) begin
         ex = (c == 3) ? 4'h5 : (c == 1) ? 4'hF : 4'h0;
         bus(1'b1, 5'h00, {c[1:0], c[1:0], 4'h0});
         shutdown_inputs <= 4'h1;
         cmp_pin(4'hF, ex);
         rd(5'h04, 32'h0000_0081);
         bus(1'b1, 5'h04, 32'h0000_0001);
         rd(5'h04, 32'h0000_0081);
         shutdown_inputs <= 4'h0;
         rd(5'h04, 32'h0000_0081);
         bus(1'b1, 5'h04, 32'h0000_0001);
         rd(5'h04, 32'h0000_0001);
         cmp_pin(4'hF, ex);
         sources <= 8'h01;
         cmp_pin(4'hF, 4'h4);
         sources <= 8'h00;
      end
      $display("shutdown levels done");
      rd(5'h0C, 32'h0000_0003);
      cmp_rd({31'h0, irq}, 32'h0000_0001);
      bus(1'b1, 5'h10, 32'h0000_0000);
      repeat (2) @(negedge clk);
      cmp_rd({31'h0, irq}, 32'h0000_0000);
      bus(1'b1, 5'h0C, 32'h0000_0003);
      rd(5'h0C, 32'h0000_0000);
      $display("interrupt done");
      bus(1'b1, 5'h00, 32'h0000_0050);
      bus(1'b1, 5'h04, 32'h0000_0041);
      shutdown_inputs <= 4'h1;
      cmp_pin(4'hA, 4'hA);
      shutdown_inputs <= 4'h0;
      cmp_pin(4'hA, 4'hA);
      rd(5'h04, 32'h0000_0041);
      sources <= 8'h01;
      cmp_pin(4'hF, 4'h4);
      $display("auto restart done");
      report_and_stop;
   end
endmodule
